// ==== logic/lcs_pkg.sv ====
// Package with register map, field positions, reset values and timing for the LED current sink control.
`default_nettype none
package lcs_pkg;
   // Printed offsets are word indexes; byte address is four times the index.
   localparam logic [15:0] IDX_INT_STATUS_TWO = 16'h4012;
   localparam logic [15:0] IDX_INT_STATUS_TWO_MASK = 16'h401A;
   localparam logic [15:0] IDX_SINK_ONE_CONTROL = 16'h404E;
   localparam logic [15:0] IDX_SINK_TWO_CONTROL = 16'h404F;
   localparam logic [15:0] IDX_POWER_STATE = 16'h4100;
   localparam logic [17:0] ADDR_INT_STATUS_TWO = {IDX_INT_STATUS_TWO, 2'b00};
   localparam logic [17:0] ADDR_INT_STATUS_TWO_MASK = {IDX_INT_STATUS_TWO_MASK, 2'b00};
   localparam logic [17:0] ADDR_SINK_ONE_CONTROL = {IDX_SINK_ONE_CONTROL, 2'b00};
   localparam logic [17:0] ADDR_SINK_TWO_CONTROL = {IDX_SINK_TWO_CONTROL, 2'b00};
   localparam logic [17:0] ADDR_POWER_STATE = {IDX_POWER_STATE, 2'b00};
   localparam int BIT_ENABLE = 15;
   localparam int BIT_DRIVE = 14;
   localparam int BIT_STATUS = 13;
   localparam int BIT_SLEEP_KEEP = 12;
   localparam int BIT_OFF_RAMP_LO = 10;
   localparam int BIT_ON_RAMP_LO = 8;
   localparam int BIT_FLAG_ONE = 6;
   localparam int BIT_FLAG_TWO = 7;
   localparam logic [1:0] RAMP_RESET = 2'h1;
   localparam logic [5:0] CODE_RESET = 6'h00;
   localparam logic [5:0] CODE_MAX = 6'h37;
   localparam logic [1:0] MASK_RESET = 2'h3;
   localparam logic [1:0] PWR_OFF = 2'h0;
   localparam logic [1:0] PWR_ON = 2'h1;
   localparam logic [1:0] PWR_SLEEP = 2'h2;
   localparam int CLK_MHZ = 125;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int STEP_MS_SLOW1 = 4;
   localparam int STEP_MS_SLOW2 = 8;
   localparam int STEP_MS_SLOW3 = 16;
endpackage
`default_nettype wire

// ==== logic/lcs_tick.sv ====
// Millisecond tick divider.
`timescale 1ns/1ps
`default_nettype none
module lcs_tick #(
   parameter int TICK_CYCLES = lcs_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   output logic tick
);
   logic [16:0] cnt_reg;
   wire last = (cnt_reg == 17'(TICK_CYCLES - 1));
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 17'h00000;
         tick <= 1'b0;
      end else begin
         cnt_reg <= last ? 17'h00000 : cnt_reg + 17'h00001;
         tick <= last;
      end
   end
endmodule
`default_nettype wire

// ==== logic/lcs_ramp.sv ====
// One channel's current code ramp stepping toward its target.
`timescale 1ns/1ps
`default_nettype none
module lcs_ramp (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic drive_on,
   input wire logic [5:0] code,
   input wire logic [1:0] on_rate,
   input wire logic [1:0] off_rate,
   output logic [5:0] level,
   output logic active
);
   logic [3:0] ms_reg;
   wire [5:0] target = drive_on ? ((code > lcs_pkg::CODE_MAX) ? lcs_pkg::CODE_MAX : code) : 6'h00;
   wire up = level < target;
   wire [1:0] rate = up ? on_rate : off_rate;
   wire [3:0] ms_last = (rate == 2'h1) ? 4'(lcs_pkg::STEP_MS_SLOW1 - 1) :
                        (rate == 2'h2) ? 4'(lcs_pkg::STEP_MS_SLOW2 - 1) : 4'(lcs_pkg::STEP_MS_SLOW3 - 1);
   wire step = tick && (ms_reg == ms_last);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level <= 6'h00;
         ms_reg <= 4'h0;
         active <= 1'b0;
      end else begin
         active <= drive_on || (level != 6'h00);
         if (level == target) begin
            ms_reg <= 4'h0;
         end else if (rate == 2'h0) begin
            level <= target;
         end else if (tick) begin
            ms_reg <= step ? 4'h0 : ms_reg + 4'h1;
            if (step) begin
               level <= up ? level + 6'h01 : level - 6'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== logic/lcs_top.sv ====
// Register file, power state handling and interrupt flags for two LED current sinks.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// RULE1 - A sink conducts only while its enable and drive bits are both one; the code also conducts with drive zero while the level ramps down.
// RULE2 - Entering OFF power state clears each sink's enable bit 15.
// RULE3 - Sleep keep bit 12 zero disables sink in SLEEP; one keeps enable control.
// RULE4 - Sleep-disabled sinks lose drive bit on entering SLEEP until software rewrites it.
// RULE5 - Software changes sink enables only in the ON power state.
// RULE6 - Drive changes ramp current gradually at the on or off ramp rate.
// RULE7 - Ramp fields 11:10 off, 9:8 on, reset 01: instant, 4, 8, 16 ms.
// RULE8 - Ramp time is proportional to steps traversed; full scale 220, 440, 880 ms.
// RULE9 - Six bit current code at 5:0, reset zero, current doubles every four steps.
// RULE10 - Codes above 11_0111 act as the maximum code.
// RULE11 - Status bit 13 reads one while enabled and regulation fails.
// RULE12 - Event flags at bit 7 and 6 set on rising regulation failure.
// RULE13 - Writing one clears an event flag; writing zero leaves it.
// RULE14 - Mask bits at same positions reset to one; zero lets flag through.
// RULE15 - Any unmasked flag raises the primary sink interrupt.
// RULE16 - Software turns on sink enable and drive before the boost converter.
// RULE17 - Switch off: drive, then boost converter, then sink enable.
// RULE18 - Without off ramp, boost off first then enable and drive together.
// RULE19 - Boost off in SLEEP only when both sinks are sleep-disabled.
// RULE20 - Ramp steps the applied code one count per step interval toward target.
// RULE21 - A millisecond tick times ramps; each channel ramps independently.
module lcs_top #(
   parameter int TICK_CYCLES = lcs_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] power_state,
   input wire logic [1:0] sink_regulation_fault,
   output logic [1:0] sink_conduct,
   output logic [5:0] sink_one_level,
   output logic [5:0] sink_two_level,
   output logic sink_irq
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0] sink_channel_enable_reg;
   logic [1:0] sink_channel_output_drive_reg;
   logic [1:0] sleep_keep_reg;
   logic [1:0] on_rate_reg [2];
   logic [1:0] off_rate_reg [2];
   logic [5:0] code_reg [2];
   logic [1:0] event_flag_reg;
   logic [1:0] event_mask_reg;
   logic [1:0] fail_prev_reg;
   logic [1:0] pstate_prev_reg;
   logic [17:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [1:0] wstrb_lo_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [5:0] level [2];
   logic [1:0] ramp_active;
   logic tick;

   function automatic logic [1:0] reg_sel(input logic [17:0] a);
      reg_sel = (a == lcs_pkg::ADDR_SINK_ONE_CONTROL) ? 2'h0 :
                (a == lcs_pkg::ADDR_SINK_TWO_CONTROL) ? 2'h1 :
                (a == lcs_pkg::ADDR_INT_STATUS_TWO) ? 2'h2 : 2'h3;
   endfunction

   function automatic logic is_mapped(input logic [17:0] a);
      is_mapped = (a == lcs_pkg::ADDR_SINK_ONE_CONTROL) || (a == lcs_pkg::ADDR_SINK_TWO_CONTROL) ||
                  (a == lcs_pkg::ADDR_INT_STATUS_TWO) || (a == lcs_pkg::ADDR_INT_STATUS_TWO_MASK) ||
                  (a == lcs_pkg::ADDR_POWER_STATE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Power state transitions.
   wire in_on = (power_state == lcs_pkg::PWR_ON);
   wire in_sleep = (power_state == lcs_pkg::PWR_SLEEP);
   wire enter_off = (power_state == lcs_pkg::PWR_OFF) && (pstate_prev_reg != lcs_pkg::PWR_OFF);
   wire enter_sleep = in_sleep && (pstate_prev_reg != lcs_pkg::PWR_SLEEP);

   // Write path decode.
   wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire [1:0] wsel = reg_sel(awaddr_reg);
   wire wr_mapped = is_mapped(awaddr_reg);
   wire wr_mask = do_write && (awaddr_reg == lcs_pkg::ADDR_INT_STATUS_TWO_MASK) && wstrb_lo_reg[0];
   wire wr_flags = do_write && (wsel == 2'h2) && wstrb_lo_reg[0];
   wire [1:0] flag_clear = wr_flags ? {wdata_reg[lcs_pkg::BIT_FLAG_TWO], wdata_reg[lcs_pkg::BIT_FLAG_ONE]}
                                    : 2'b00;
   wire [1:0] fail_now = sink_regulation_fault & sink_channel_enable_reg;
   wire [1:0] fail_rise = fail_now & ~fail_prev_reg;

   ////////////////////////////////////////////////////////////////////////////////
   lcs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         wire wr_ctl = do_write && (wsel == 2'(g));
         wire sleep_off = in_sleep && !sleep_keep_reg[g];
         // Ramp runs per channel off the shared millisecond tick; see RULE6 see RULE20 see RULE21
         lcs_ramp u_ramp (
            .sys_clk(sys_clk),
            .rst(rst),
            .tick(tick),
            .drive_on(sink_channel_output_drive_reg[g]),
            .code(code_reg[g]),
            .on_rate(on_rate_reg[g]),
            .off_rate(off_rate_reg[g]),
            .level(level[g]),
            .active(ramp_active[g])
         );
         // Conduct only with enable, drive or a down ramp, and not sleep-disabled; see RULE1 see RULE3
         assign sink_conduct[g] = sink_channel_enable_reg[g] && ramp_active[g] && !sleep_off;

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               sink_channel_enable_reg[g] <= 1'b0;
               sink_channel_output_drive_reg[g] <= 1'b0;
               sleep_keep_reg[g] <= 1'b0;
               on_rate_reg[g] <= lcs_pkg::RAMP_RESET;
               off_rate_reg[g] <= lcs_pkg::RAMP_RESET;
               code_reg[g] <= lcs_pkg::CODE_RESET;
            end else begin
               if (wr_ctl && wstrb_lo_reg[1]) begin
                  if (in_on) begin
                     sink_channel_enable_reg[g] <= wdata_reg[lcs_pkg::BIT_ENABLE]; // see RULE5
                  end
                  sink_channel_output_drive_reg[g] <= wdata_reg[lcs_pkg::BIT_DRIVE];
                  sleep_keep_reg[g] <= wdata_reg[lcs_pkg::BIT_SLEEP_KEEP];
                  off_rate_reg[g] <= wdata_reg[lcs_pkg::BIT_OFF_RAMP_LO +: 2]; // see RULE7
                  on_rate_reg[g] <= wdata_reg[lcs_pkg::BIT_ON_RAMP_LO +: 2]; // see RULE7
               end
               if (wr_ctl && wstrb_lo_reg[0]) begin
                  code_reg[g] <= wdata_reg[5:0]; // see RULE9
               end
               if (enter_sleep && !sleep_keep_reg[g]) begin
                  sink_channel_output_drive_reg[g] <= 1'b0; // see RULE4
               end
               if (enter_off) begin
                  sink_channel_enable_reg[g] <= 1'b0; // see RULE2
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Event flags: a set in the same cycle as a clear wins.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         event_flag_reg <= 2'b00;
         event_mask_reg <= lcs_pkg::MASK_RESET;
         fail_prev_reg <= 2'b00;
         pstate_prev_reg <= lcs_pkg::PWR_OFF;
      end else begin
         fail_prev_reg <= fail_now;
         pstate_prev_reg <= power_state;
         event_flag_reg <= (event_flag_reg & ~flag_clear) | fail_rise; // see RULE12 see RULE13
         if (wr_mask) begin
            event_mask_reg <= {wdata_reg[lcs_pkg::BIT_FLAG_TWO], wdata_reg[lcs_pkg::BIT_FLAG_ONE]}; // see RULE14
         end
      end
   end

   assign sink_irq = |(event_flag_reg & ~event_mask_reg); // see RULE15

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel.
   assign s_axi_awready = !aw_have_reg;
   assign s_axi_wready = !w_have_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 18'h00000;
         wdata_reg <= 32'h00000000;
         wstrb_lo_reg <= 2'b00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_lo_reg <= s_axi_wstrb[1:0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.
   wire [1:0] rsel = reg_sel(s_axi_araddr);
   wire [15:0] ctl_word [2];
   generate
      for (g = 0; g < 2; g++) begin : g_rd
         // Status reads failure only while enabled; see RULE11
         assign ctl_word[g] = {sink_channel_enable_reg[g], sink_channel_output_drive_reg[g], fail_now[g],
                               sleep_keep_reg[g], off_rate_reg[g], on_rate_reg[g], 2'b00, code_reg[g]};
      end
   endgenerate
   wire [15:0] flag_word = {8'h00, event_flag_reg, 6'h00};
   wire [15:0] mask_word = {8'h00, event_mask_reg, 6'h00};
   wire [15:0] pwr_word = {14'h0000, power_state};
   wire [15:0] rd_word = (rsel == 2'h0) ? ctl_word[0] :
                         (rsel == 2'h1) ? ctl_word[1] :
                         (rsel == 2'h2) ? flag_word :
                         (s_axi_araddr == lcs_pkg::ADDR_INT_STATUS_TWO_MASK) ? mask_word :
                         (s_axi_araddr == lcs_pkg::ADDR_POWER_STATE) ? pwr_word : 16'h0000;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Applied codes, saturated at the top code; see RULE8 see RULE10
   assign sink_one_level = level[0];
   assign sink_two_level = level[1];
endmodule
`default_nettype wire

// ==== sim/lcs_led_string.sv ====
// Model of the LED strings hanging on the two current sinks.
`timescale 1ns/1ps
`default_nettype none
module lcs_led_string (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] sink_conduct,
   input wire logic [1:0] open_load,
   output logic [1:0] sink_regulation_fault
);
   // An open string cannot carry the demanded current, so regulation fails.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sink_regulation_fault <= 2'h0;
      end else begin
         sink_regulation_fault <= sink_conduct & open_load;
      end
   end
endmodule
`default_nettype wire

// ==== sim/lcs_top_chk.sv ====
// Checker of bus timing, code saturation and power state rules.
`timescale 1ns/1ps
`default_nettype none
module lcs_top_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] power_state,
   input wire logic [1:0] sink_conduct,
   input wire logic [5:0] sink_one_level,
   input wire logic [5:0] sink_two_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_b_after_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_after_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   chk_one_level_max: assert property (sink_one_level <= lcs_pkg::CODE_MAX)
      else $error("sink one level above maximum");
   chk_two_level_max: assert property (sink_two_level <= lcs_pkg::CODE_MAX)
      else $error("sink two level above maximum");
   chk_off_dark: assert property (power_state == lcs_pkg::PWR_OFF |=> sink_conduct == 2'h0)
      else $error("sink conducts in off state");
endmodule
bind lcs_top lcs_top_chk u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .power_state,
   .sink_conduct, .sink_one_level, .sink_two_level);
`default_nettype wire

// ==== sim/lcs_top_tb_top.sv ====
// Self-checking testbench of the LED current sink control.
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb_top;
   logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sink_irq;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, power_state, sink_regulation_fault, sink_conduct, open_load;
   logic [5:0] sink_one_level, sink_two_level;
   int n_errors, checked, n, t, c;
   logic [1:0] bq[$];
   logic [31:0] rq[$];
   lcs_top #(.TICK_CYCLES(10)) dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_state,
      .sink_regulation_fault, .sink_conduct, .sink_one_level, .sink_two_level, .sink_irq);
   lcs_led_string led (.sys_clk, .rst, .sink_conduct, .open_load, .sink_regulation_fault);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input string nm);
      n_errors++;
      $display("[FAIL] %s expected done seen timeout", nm);
      wrap_up();
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] e);
      int k;
      bq.push_back(e);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 50) tmo("write");
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] e);
      int k;
      rq.push_back(e);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 50) tmo("read");
   endtask
   task automatic wait_lvl(input bit s, input logic [5:0] v, input int lim);
      n = 0;
      while ((s ? sink_two_level : sink_one_level) !== v && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == lim) tmo("level");
   endtask
   // Monitor takes the oldest expected answer whenever the bus delivers one.
   always @(posedge sys_clk) begin
      if (!rst && s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
      if (!rst && s_axi_rvalid && s_axi_rready) chk("rdata", s_axi_rdata, rq.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      power_state = lcs_pkg::PWR_OFF;
      open_load = 2'h0;
      void'($urandom(48621));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(lcs_pkg::ADDR_SINK_ONE_CONTROL, 32'h0500);
      rd(lcs_pkg::ADDR_SINK_TWO_CONTROL, 32'h0500);
      rd(lcs_pkg::ADDR_INT_STATUS_TWO_MASK, 32'h00C0);
      rd(lcs_pkg::ADDR_INT_STATUS_TWO, 32'h0000);
      wr(18'h00004, 16'hFFFF, 2'h2);
      rd(18'h00004, 32'h0000);
      wr(lcs_pkg::ADDR_SINK_ONE_CONTROL, 16'h8000, 2'h0);
      rd(lcs_pkg::ADDR_SINK_ONE_CONTROL, 32'h0000);
      power_state <= lcs_pkg::PWR_ON;
      c = $urandom_range(63, 1);
      t = (c > 55) ? 55 : c;
      wr(lcs_pkg::ADDR_SINK_ONE_CONTROL, 16'hC500 | 16'(c), 2'h0);
      @(posedge sys_clk);
      chk("conduct one", {31'h0, sink_conduct[0]}, 32'h1);
      wait_lvl(1'b0, t[5:0], 3000);
      chk("on ramp time", {31'h0, n >= (t - 1) * 40 - 10 && n <= t * 40}, 32'h1);
      wr(lcs_pkg::ADDR_SINK_TWO_CONTROL, 16'hC03F, 2'h0);
      wait_lvl(1'b1, 6'h37, 4);
      chk("level one", {26'h0, sink_one_level}, t);
      wr(lcs_pkg::ADDR_SINK_ONE_CONTROL, 16'h8900 | 16'(c), 2'h0);
      wait_lvl(1'b0, 6'h00, 5000);
      chk("off ramp time", {31'h0, n >= (t - 1) * 80 - 10 && n <= t * 80}, 32'h1);
      @(posedge sys_clk);
      chk("dark one", {31'h0, sink_conduct[0]}, 32'h0);
      open_load <= 2'h2;
      repeat (4) @(posedge sys_clk);
      rd(lcs_pkg::ADDR_INT_STATUS_TWO, 32'h0080);
      rd(lcs_pkg::ADDR_SINK_TWO_CONTROL, 32'hE03F);
      chk("irq masked", {31'h0, sink_irq}, 32'h0);
      wr(lcs_pkg::ADDR_INT_STATUS_TWO_MASK, 16'h0040, 2'h0);
      @(posedge sys_clk);
      chk("irq raised", {31'h0, sink_irq}, 32'h1);
      wr(lcs_pkg::ADDR_INT_STATUS_TWO, 16'h0000, 2'h0);
      rd(lcs_pkg::ADDR_INT_STATUS_TWO, 32'h0080);
      open_load <= 2'h0;
      wr(lcs_pkg::ADDR_INT_STATUS_TWO, 16'h0080, 2'h0);
      rd(lcs_pkg::ADDR_INT_STATUS_TWO, 32'h0000);
      chk("irq cleared", {31'h0, sink_irq}, 32'h0);
      wr(lcs_pkg::ADDR_SINK_ONE_CONTROL, 16'hD005, 2'h0);
      wait_lvl(1'b0, 6'h05, 4);
      power_state <= lcs_pkg::PWR_SLEEP;
      repeat (3) @(posedge sys_clk);
      chk("sleep conduct", {30'h0, sink_conduct}, 32'h1);
      rd(lcs_pkg::ADDR_SINK_TWO_CONTROL, 32'h803F);
      wr(lcs_pkg::ADDR_SINK_TWO_CONTROL, 16'h003F, 2'h0);
      power_state <= lcs_pkg::PWR_ON;
      rd(lcs_pkg::ADDR_SINK_TWO_CONTROL, 32'h803F);
      rd(lcs_pkg::ADDR_SINK_ONE_CONTROL, 32'hD005);
      power_state <= lcs_pkg::PWR_OFF;
      repeat (3) @(posedge sys_clk);
      rd(lcs_pkg::ADDR_SINK_ONE_CONTROL, 32'h5005);
      chk("off conduct", {30'h0, sink_conduct}, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
